// ===== core/epsld_core.sv
// Indicator driver for PHY status with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module epsld_core #(
   parameter int BLINK_HALF_CYCLES = epsld_pkg::BLINK_HALF_CYCLES
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire epsld_pkg::epsld_phy_status_t phy_status_in,
   input wire logic [epsld_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output epsld_pkg::epsld_ind_t indicators_out
);
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (BLINK_HALF_CYCLES < 1) begin : g_bad_half
      $error("BLINK_HALF_CYCLES must be at least one");
   end

   localparam logic [epsld_pkg::CNT_W-1:0] HALF_DEFAULT =
      epsld_pkg::CNT_W'(BLINK_HALF_CYCLES);

   function automatic logic sel(input logic [epsld_pkg::ADDR_W-1:0] a,
                                input logic [epsld_pkg::ADDR_W-1:0] off);
      sel = (a == off);
   endfunction : sel

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   epsld_pkg::epsld_bus_state_t bus_r, bus_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [epsld_pkg::CNT_W-1:0] half_r, half_nxt;
   logic [epsld_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic phase_r, phase_nxt;
   epsld_pkg::epsld_ind_t ind_r, ind_nxt;
   logic req;
   logic [31:0] status_word;
   logic [epsld_pkg::CNT_W-1:0] half_eff;

   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & (bus_r == epsld_pkg::BUS_IDLE);
   assign avs_readdata_out = rdata_r;

   always_comb begin
      status_word = 32'h0;
      status_word[epsld_pkg::ST_LINK_UP] = phy_status_in.link_up;
      status_word[epsld_pkg::ST_RECEIVING] = phy_status_in.receiving;
      status_word[epsld_pkg::ST_TRANSMITTING] = phy_status_in.transmitting;
      status_word[epsld_pkg::ST_COLLISION] = phy_status_in.collision;
      status_word[epsld_pkg::ST_FULL_DUPLEX] = phy_status_in.full_duplex;
      status_word[epsld_pkg::ST_SPEED_100] = phy_status_in.speed_100;
      status_word[epsld_pkg::ST_PHASE] = phase_r;
      status_word[epsld_pkg::ST_IND_LSB +: 5] = ind_r;
   end

   always_comb begin
      bus_nxt = epsld_pkg::BUS_IDLE;
      rdata_nxt = rdata_r;
      half_nxt = half_r;
      if (bus_r == epsld_pkg::BUS_IDLE) begin
         if (req) begin
            bus_nxt = epsld_pkg::BUS_ACK;
         end
         if (avs_read_in) begin
            if (sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF)) begin
               rdata_nxt = half_r;
            end else if (sel(avs_address_in, epsld_pkg::OFF_STATUS)) begin
               rdata_nxt = status_word;
            end else if (sel(avs_address_in, epsld_pkg::OFF_COUNT)) begin
               rdata_nxt = cnt_r;
            end else begin
               rdata_nxt = 32'h0;
            end
         end
      end else if (avs_write_in && sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF)) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_in[b]) begin
               half_nxt[8*b +: 8] = avs_writedata_in[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bus_r <= epsld_pkg::BUS_IDLE;
         rdata_r <= epsld_pkg::RDATA_RESET;
         half_r <= HALF_DEFAULT;
      end else begin
         bus_r <= bus_nxt;
         rdata_r <= rdata_nxt;
         half_r <= half_nxt;
      end
   end

   // ****************************************************************
   // Blink divider and indicators
   // ****************************************************************
   assign half_eff = (half_r == '0) ? epsld_pkg::CNT_W'(1) : half_r;

   always_comb begin
      cnt_nxt = cnt_r + epsld_pkg::CNT_W'(1);
      phase_nxt = phase_r;
      if (cnt_r >= half_eff - epsld_pkg::CNT_W'(1)) begin
         cnt_nxt = '0;
         phase_nxt = ~phase_r;
      end
      ind_nxt = epsld_pkg::IND_RESET;
      ind_nxt.receive_activity_indicator_n = phy_status_in.receiving ? phase_r : 1'b1;
      ind_nxt.collision_indicator_n = ~phy_status_in.collision;
      if (!phy_status_in.link_up) begin
         ind_nxt.link_state_indicator_n = 1'b1;
      end else if (phy_status_in.receiving || phy_status_in.transmitting) begin
         ind_nxt.link_state_indicator_n = phase_r;
      end else begin
         ind_nxt.link_state_indicator_n = 1'b0;
      end
      ind_nxt.duplex_indicator_n = ~phy_status_in.full_duplex;
      ind_nxt.line_rate_indicator_n = ~phy_status_in.speed_100;
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_r <= epsld_pkg::CNT_RESET;
         phase_r <= 1'b0;
         ind_r <= epsld_pkg::IND_RESET;
      end else begin
         cnt_r <= cnt_nxt;
         phase_r <= phase_nxt;
         ind_r <= ind_nxt;
      end
   end

   assign indicators_out = ind_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence s_rx_held;
      phy_status_in.receiving [*2];
   endsequence

   sequence s_link_traffic;
      phy_status_in.link_up && (phy_status_in.receiving || phy_status_in.transmitting);
   endsequence

   a_rx_blink_follow: assert property (
      s_rx_held |-> indicators_out.receive_activity_indicator_n == $past(phase_r))
      else $error("receive indicator does not follow blink phase");
   a_rx_idle_high: assert property (
      !phy_status_in.receiving |=> indicators_out.receive_activity_indicator_n)
      else $error("receive indicator low while idle");
   a_collision_level: assert property (
      phy_status_in.collision |=> !indicators_out.collision_indicator_n)
      else $error("collision indicator not low on collision");
   a_link_steady_low: assert property (
      (phy_status_in.link_up && !phy_status_in.receiving && !phy_status_in.transmitting)
      |=> !indicators_out.link_state_indicator_n)
      else $error("link indicator not steady low");
   a_link_blink_phase: assert property (
      s_link_traffic |=> indicators_out.link_state_indicator_n == $past(phase_r))
      else $error("link indicator not blinking with traffic");
   a_duplex_level: assert property (
      1'b1 |=> indicators_out.duplex_indicator_n == !$past(phy_status_in.full_duplex))
      else $error("duplex indicator wrong");
   a_rate_level: assert property (
      1'b1 |=> indicators_out.line_rate_indicator_n == !$past(phy_status_in.speed_100))
      else $error("rate indicator wrong");
   a_link_down_high: assert property (
      !phy_status_in.link_up |=> indicators_out.link_state_indicator_n)
      else $error("link indicator low while link down");
   a_blink_toggle_time: assert property (
      $changed(phase_r) |-> $past(cnt_r) >= $past(half_eff) - epsld_pkg::CNT_W'(1))
      else $error("blink phase toggled off schedule");
   a_bus_answer_bound: assert property (
      req |-> ##[0:1] !avs_waitrequest_out)
      else $error("bus answer late");

   // ****************************************************************
   // Bus slave checks
   // ****************************************************************
   sequence s_read_taken;
      (bus_r == epsld_pkg::BUS_IDLE) && avs_read_in;
   endsequence

   sequence s_write_taken;
      (bus_r == epsld_pkg::BUS_ACK) && avs_write_in;
   endsequence

   a_wait_first_cycle: assert property (
      (bus_r == epsld_pkg::BUS_IDLE) && req
      |-> avs_waitrequest_out)
      else $error("no wait state on new request");
   a_ack_wait_low: assert property (
      (bus_r == epsld_pkg::BUS_ACK)
      |-> !avs_waitrequest_out)
      else $error("wait request high in answer cycle");
   a_ack_one_cycle: assert property (
      (bus_r == epsld_pkg::BUS_ACK)
      |=> (bus_r == epsld_pkg::BUS_IDLE))
      else $error("answer state held too long");
   a_ack_after_req: assert property (
      (bus_r == epsld_pkg::BUS_IDLE) && req
      |=> (bus_r == epsld_pkg::BUS_ACK))
      else $error("request not answered");
   a_idle_stays_idle: assert property (
      (bus_r == epsld_pkg::BUS_IDLE) && !req
      |=> (bus_r == epsld_pkg::BUS_IDLE))
      else $error("answer without request");
   a_rdata_hold_ack: assert property (
      (bus_r == epsld_pkg::BUS_ACK)
      |=> $stable(avs_readdata_out))
      else $error("read data moved after answer");
   a_rdata_hold_idle: assert property (
      (bus_r == epsld_pkg::BUS_IDLE) && !avs_read_in
      |=> $stable(avs_readdata_out))
      else $error("read data moved without read");
   a_read_half: assert property (
      s_read_taken ##0 sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF)
      |=> avs_readdata_out == $past(half_r))
      else $error("half period read wrong");
   a_read_status: assert property (
      s_read_taken ##0 sel(avs_address_in, epsld_pkg::OFF_STATUS)
      |=> avs_readdata_out == $past(status_word))
      else $error("status read wrong");
   a_read_count: assert property (
      s_read_taken ##0 sel(avs_address_in, epsld_pkg::OFF_COUNT)
      |=> avs_readdata_out == $past(cnt_r))
      else $error("counter read wrong");
   a_read_unmapped: assert property (
      s_read_taken ##0 (!sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF)
      && !sel(avs_address_in, epsld_pkg::OFF_STATUS)
      && !sel(avs_address_in, epsld_pkg::OFF_COUNT))
      |=> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_write_half: assert property (
      s_write_taken ##0 (sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF) && avs_byteenable_in == 4'hF)
      |=> half_r == $past(avs_writedata_in))
      else $error("half period write lost");
   a_half_kept: assert property (
      !((bus_r == epsld_pkg::BUS_ACK) && avs_write_in && sel(avs_address_in, epsld_pkg::OFF_BLINK_HALF))
      |=> $stable(half_r))
      else $error("half period changed without write");

   // ****************************************************************
   // Blink divider and indicator checks
   // ****************************************************************
   sequence s_wrap;
      cnt_r >= half_eff - epsld_pkg::CNT_W'(1);
   endsequence

   a_count_wrap: assert property (
      s_wrap
      |=> cnt_r == '0)
      else $error("counter did not wrap");
   a_phase_flip: assert property (
      s_wrap
      |=> phase_r != $past(phase_r))
      else $error("phase did not flip at wrap");
   a_count_step: assert property (
      cnt_r < half_eff - epsld_pkg::CNT_W'(1)
      |=> cnt_r == $past(cnt_r) + epsld_pkg::CNT_W'(1))
      else $error("counter did not step");
   a_phase_hold: assert property (
      cnt_r < half_eff - epsld_pkg::CNT_W'(1)
      |=> $stable(phase_r))
      else $error("phase flipped between wraps");
   a_rx_low_phase: assert property (
      phy_status_in.receiving && !phase_r
      |=> !indicators_out.receive_activity_indicator_n)
      else $error("receive indicator not low in low phase");
   a_rx_high_phase: assert property (
      phy_status_in.receiving && phase_r
      |=> indicators_out.receive_activity_indicator_n)
      else $error("receive indicator not high in high phase");
   a_link_blink_low: assert property (
      s_link_traffic ##0 !phase_r
      |=> !indicators_out.link_state_indicator_n)
      else $error("link indicator not low in low phase");
   a_collision_clear: assert property (
      !phy_status_in.collision
      |=> indicators_out.collision_indicator_n)
      else $error("collision indicator low without collision");
endmodule : epsld_core

// ===== shared/epsld_pkg.sv
// Package for the Ethernet PHY status indicator driver
package epsld_pkg;
   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFF_BLINK_HALF = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h8;
   // ****************************************************************
   // Status register fields
   // ****************************************************************
   localparam int ST_LINK_UP = 0;
   localparam int ST_RECEIVING = 1;
   localparam int ST_TRANSMITTING = 2;
   localparam int ST_COLLISION = 3;
   localparam int ST_FULL_DUPLEX = 4;
   localparam int ST_SPEED_100 = 5;
   localparam int ST_PHASE = 6;
   localparam int ST_IND_LSB = 8;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_KHZ = 50000;
   localparam int BLINK_HALF_MS = 50;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_KHZ;
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;
   localparam logic [31:0] RDATA_RESET = 32'h0;
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } epsld_bus_state_t;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic collision;
      logic transmitting;
      logic receiving;
      logic link_up;
   } epsld_phy_status_t;

   typedef struct packed {
      logic line_rate_indicator_n;
      logic duplex_indicator_n;
      logic link_state_indicator_n;
      logic collision_indicator_n;
      logic receive_activity_indicator_n;
   } epsld_ind_t;

   localparam epsld_ind_t IND_RESET = 5'h1F;
endpackage : epsld_pkg

// ===== testbench/epsld_lamps.sv
// Model of the active-low indicator lamps on the outputs
`timescale 1ns/1ps
module epsld_lamps (
   input wire epsld_pkg::epsld_ind_t ind_in,
   output logic [4:0] lit_out
);
   // ****************************************************************
   // Lamp lights while its output is low
   // ****************************************************************
   assign lit_out = ~ind_in;
endmodule : epsld_lamps

// ===== testbench/epsld_core_tb.sv
// Self-checking testbench for the PHY status indicator driver
`timescale 1ns/1ps
module epsld_core_tb;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   epsld_pkg::epsld_phy_status_t phy = '0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   epsld_pkg::epsld_ind_t ind;
   logic [4:0] lit;
   logic [31:0] q;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int t;
   epsld_core #(.BLINK_HALF_CYCLES(4)) i_epsld_core (.mclk_in(mclk_in),
      .reset_n_in(reset_n_in), .phy_status_in(phy), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_req), .indicators_out(ind));
   epsld_lamps i_epsld_lamps (.ind_in(ind), .lit_out(lit));
   initial begin
      forever #10 mclk_in = ~mclk_in;
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge mclk_in iff wait_req === 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic set_phy(input logic [5:0] s);
      @(posedge mclk_in);
      phy <= s;
      repeat (2) @(posedge mclk_in);
   endtask : set_phy
   task automatic toggles(input int b, input int n);
      logic prev;
      t = 0;
      @(negedge mclk_in);
      prev = lit[b];
      repeat (n) begin
         @(negedge mclk_in);
         if (lit[b] !== prev) t++;
         prev = lit[b];
      end
   endtask : toggles
   task automatic give_verdict();
      $display("compared %0d, fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_static();
      for (int i = 0; i < 8; i++) begin
         set_phy({i[2], i[1], i[0], 3'b000});
         @(negedge mclk_in);
         chk("collision", {31'h0, !i[0]}, {31'h0, ind.collision_indicator_n});
         chk("duplex", {31'h0, !i[1]}, {31'h0, ind.duplex_indicator_n});
         chk("rate", {31'h0, !i[2]}, {31'h0, ind.line_rate_indicator_n});
         chk("link down", 32'h1, {31'h0, ind.link_state_indicator_n});
      end
   endtask : t_static
   task automatic t_traffic();
      set_phy(6'h01);
      toggles(2, 16);
      chk("idle link toggles", 32'h0, t);
      chk("idle link lamp", 32'h1, {31'h0, lit[2]});
      chk("idle rx lamp", 32'h0, {31'h0, lit[0]});
      set_phy(6'h03);
      toggles(0, 16);
      chk("rx toggles", 32'h4, t);
      toggles(2, 16);
      chk("link rx toggles", 32'h4, t);
      set_phy(6'h05);
      toggles(2, 16);
      chk("link tx toggles", 32'h4, t);
      toggles(0, 16);
      chk("rx toggles on tx", 32'h0, t);
      set_phy(6'h02);
      toggles(2, 16);
      chk("down link toggles", 32'h0, t);
      chk("down link lamp", 32'h0, {31'h0, lit[2]});
   endtask : t_traffic
   task automatic t_regs();
      bus(1'b0, 4'h0, 32'h0);
      chk("half period", 32'h4, q);
      set_phy(6'h31);
      bus(1'b0, 4'h4, 32'h0);
      chk("status", 32'h0000_0331, q & ~32'h0000_0040);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, 4'h0, 32'h0000_0008);
      bus(1'b0, 4'h0, 32'h0);
      chk("half period new", 32'h8, q);
      set_phy(6'h03);
      toggles(0, 32);
      chk("slow rx toggles", 32'h4, t);
   endtask : t_regs
   // ****************************************************************
   // Main sequence and hang guard
   // ****************************************************************
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("indicators after reset", 32'h1F, {27'h0, ind});
      t_static();
      t_traffic();
      t_regs();
      give_verdict();
   end
endmodule : epsld_core_tb
